/* File: logic/fdbr_remap_ctrl.sv */
// What this block does
// - software can write a control that picks single-bank or dual-bank.
// - software can write a control that picks normal or swapped mapping.
// - any reset clears both controls to single-bank, normal mapping.
// - while the boot sequence runs, writes to both controls are ignored.
// - in dual-bank mode each flash half is shown as its own region.
// - in dual-bank mode the swapped mapping exchanges bank 0 and bank 1 address ranges; single-bank ignores it.
// - application cores stay held after reset until activated.
//
// Purpose: bank mode and remap control with address translation
// Assumes: all inputs come from logic on clk; write strobes are one cycle
// Notes: translated access appears one cycle after the request
`timescale 1ns/100ps
module fdbr_remap_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic boot_busy,
    input wire logic bank_mode_wr,
    input wire logic bank_mode_wdata,
    input wire logic remap_wr,
    input wire logic remap_wdata,
    input wire logic app_activate,
    input wire fdbr_pkg::fdbr_req_s req,
    output logic dual_bank_q,
    output logic remap_q,
    output logic remap_active_q,
    output logic app_hold_q,
    output fdbr_pkg::fdbr_rsp_s rsp_q
);
    logic dual_bank_d;
    logic remap_d;
    fdbr_pkg::fdbr_app_e app_q;
    fdbr_pkg::fdbr_app_e app_d;
    fdbr_pkg::fdbr_rsp_s rsp_d;

    wire logic user_write_ok;
    wire logic mode_take;
    wire logic remap_take;
    wire logic activate_take;

    // boot code must not leave anything behind in these controls
    assign user_write_ok = ~boot_busy;
    assign mode_take = bank_mode_wr & user_write_ok;
    assign remap_take = remap_wr & user_write_ok;
    assign activate_take = app_activate & user_write_ok;

    assign dual_bank_d = mode_take ? bank_mode_wdata : dual_bank_q;
    assign remap_d = remap_take ? remap_wdata : remap_q;

    always_comb begin
        app_d = app_q;
        unique case (app_q)
            fdbr_pkg::FDBR_APP_HOLD: begin
                if (activate_take) begin
                    app_d = fdbr_pkg::FDBR_APP_RUN;
                end
            end
            fdbr_pkg::FDBR_APP_RUN: begin
                app_d = fdbr_pkg::FDBR_APP_RUN;
            end
        endcase
    end

    // translation uses the controls already in force, so a write lands
    // on the access after it; software sits in SRAM across the switch
    fdbr_xlate u_xlate (
        .dual_bank(dual_bank_q),
        .remap(remap_q),
        .req(req),
        .rsp(rsp_d)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            dual_bank_q <= fdbr_pkg::FDBR_DUAL_RST;
            remap_q <= fdbr_pkg::FDBR_REMAP_RST;
        end else begin
            dual_bank_q <= dual_bank_d;
            remap_q <= remap_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            remap_active_q <= 1'b0;
        end else begin
            remap_active_q <= dual_bank_d & remap_d;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            app_q <= fdbr_pkg::FDBR_APP_HOLD;
            app_hold_q <= fdbr_pkg::FDBR_HOLD_RST;
        end else begin
            app_q <= app_d;
            app_hold_q <= (app_d == fdbr_pkg::FDBR_APP_HOLD);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // checks
    property p_reset_clear;
        @(posedge clk) reset |=> !dual_bank_q && !remap_q && app_hold_q;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("controls not cleared by reset");

    property p_boot_lock;
        @(posedge clk) disable iff (reset)
        boot_busy |=> dual_bank_q == $past(dual_bank_q)
            && remap_q == $past(remap_q)
            && app_hold_q == $past(app_hold_q);
    endproperty
    a_boot_lock: assert property (p_boot_lock)
        else $error("control changed during boot");

    property p_mode_write;
        @(posedge clk) disable iff (reset)
        bank_mode_wr && !boot_busy |=> dual_bank_q == $past(bank_mode_wdata);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("bank mode write not taken");

    property p_remap_write;
        @(posedge clk) disable iff (reset)
        remap_wr && !boot_busy |=> remap_q == $past(remap_wdata)
            ##1 remap_q == $past(remap_wdata, 2) || $past(remap_take);
    endproperty
    a_remap_write: assert property (p_remap_write)
        else $error("remap write not taken or not held");

    property p_single_linear;
        @(posedge clk) disable iff (reset)
        req.valid && !dual_bank_q |=> rsp_q.valid
            && rsp_q.addr == $past(req.addr)
            && rsp_q.region == fdbr_pkg::FDBR_REGION_LOW;
    endproperty
    a_single_linear: assert property (p_single_linear)
        else $error("single-bank access not linear");

    property p_dual_halves;
        @(posedge clk) disable iff (reset)
        req.valid && dual_bank_q |=>
            rsp_q.region == $past(req.addr[fdbr_pkg::FDBR_HALF_BIT])
            && rsp_q.addr[fdbr_pkg::FDBR_HALF_BIT-1:0]
               == $past(req.addr[fdbr_pkg::FDBR_HALF_BIT-1:0]);
    endproperty
    a_dual_halves: assert property (p_dual_halves)
        else $error("dual-bank region split wrong");

    property p_swap;
        @(posedge clk) disable iff (reset)
        req.valid && dual_bank_q |=>
            rsp_q.addr[fdbr_pkg::FDBR_HALF_BIT]
            == ($past(req.addr[fdbr_pkg::FDBR_HALF_BIT]) ^ $past(remap_q));
    endproperty
    a_swap: assert property (p_swap)
        else $error("bank swap wrong");

    property p_hold_until_activate;
        @(posedge clk) disable iff (reset)
        app_hold_q && !(app_activate && !boot_busy) |=> app_hold_q;
    endproperty
    a_hold_until_activate: assert property (p_hold_until_activate)
        else $error("application cores released without activation");

    property p_activate;
        @(posedge clk) disable iff (reset)
        app_activate && !boot_busy |=> !app_hold_q ##1 !app_hold_q;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation did not release cores");

    property p_active_flag;
        @(posedge clk) disable iff (reset)
        1'b1 |=> remap_active_q == (dual_bank_q && remap_q);
    endproperty
    a_active_flag: assert property (p_active_flag)
        else $error("remap active flag wrong");

    // a control only moves on a taken write of its own
    property p_mode_hold;
        @(posedge clk) disable iff (reset)
        !(bank_mode_wr && !boot_busy) |=> dual_bank_q == $past(dual_bank_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("bank mode moved without a write");

    property p_remap_hold;
        @(posedge clk) disable iff (reset)
        !(remap_wr && !boot_busy) |=> remap_q == $past(remap_q);
    endproperty
    a_remap_hold: assert property (p_remap_hold)
        else $error("remap moved without a write");

    property p_valid_pass;
        @(posedge clk) disable iff (reset)
        1'b1 |=> rsp_q.valid == $past(req.valid);
    endproperty
    a_valid_pass: assert property (p_valid_pass)
        else $error("access not shown for exactly one cycle");

    c_dual_on: cover property (@(posedge clk) disable iff (reset)
        mode_take && bank_mode_wdata);
    c_swap_access: cover property (@(posedge clk) disable iff (reset)
        req.valid && dual_bank_q && remap_q);
    c_boot_refused: cover property (@(posedge clk) disable iff (reset)
        boot_busy && remap_wr);
    c_release: cover property (@(posedge clk) disable iff (reset)
        app_hold_q ##1 !app_hold_q);
    c_normal_write: cover property (@(posedge clk) disable iff (reset)
        remap_take && !remap_wdata);
endmodule

/* File: logic/fdbr_pkg.sv */
// Purpose: shared constants and carriers for the code flash bank/remap block
// Assumes: code flash window addressed by a byte offset of FDBR_ADDR_W bits
// Notes: the top bit of the offset picks the half (bank) in dual-bank mode
package fdbr_pkg;

    // width of the code flash offset; plain default, resize per device
    localparam int FDBR_ADDR_W = 22;
    localparam int FDBR_HALF_BIT = FDBR_ADDR_W - 1;

    // reset values: single-bank, normal mapping, application cores held
    localparam logic FDBR_DUAL_RST = 1'b0;
    localparam logic FDBR_REMAP_RST = 1'b0;
    localparam logic FDBR_HOLD_RST = 1'b1;

    // region codes shown with each translated access
    localparam logic FDBR_REGION_LOW = 1'b0;
    localparam logic FDBR_REGION_HIGH = 1'b1;

    typedef enum logic {
        FDBR_APP_HOLD = 1'b0,
        FDBR_APP_RUN = 1'b1
    } fdbr_app_e;

    // access from a core into the code flash window
    typedef struct packed {
        logic valid;
        logic [FDBR_ADDR_W-1:0] addr;
    } fdbr_req_s;

    // translated access toward the flash array
    typedef struct packed {
        logic valid;
        logic region;
        logic [FDBR_ADDR_W-1:0] addr;
    } fdbr_rsp_s;

endpackage

/* File: logic/fdbr_xlate.sv */
// Purpose: combinational translation of a code flash offset to the array
// Assumes: controls come from the register stage of the top module
// Notes: no state; the top registers the result
`timescale 1ns/100ps
module fdbr_xlate (
    input wire logic dual_bank,
    input wire logic remap,
    input wire fdbr_pkg::fdbr_req_s req,
    output fdbr_pkg::fdbr_rsp_s rsp
);
    wire logic logical_half;
    wire logic swap_active;
    wire logic phys_half;
    wire logic region;

    assign logical_half = req.addr[fdbr_pkg::FDBR_HALF_BIT];
    // swap is meaningless without two banks, so single mode ignores it
    assign swap_active = dual_bank & remap;
    assign phys_half = logical_half ^ swap_active;
    // dual mode shows each half as its own region; single shows one
    assign region = dual_bank ? logical_half
                              : fdbr_pkg::FDBR_REGION_LOW;

    assign rsp.valid = req.valid;
    assign rsp.region = region;
    assign rsp.addr = {phys_half, req.addr[fdbr_pkg::FDBR_HALF_BIT-1:0]};
endmodule

/* File: test/fdbr_testbench.sv */
// Purpose: self-checking bench for the bank mode and remap control block
// Assumes: fixed one-cycle answers; no waits on design handshakes
// Notes: inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module testbench;
    localparam int W = fdbr_pkg::FDBR_ADDR_W;
    localparam logic [W-1:0] A_LO = 22'h012344;
    // same offset in the upper half
    localparam logic [W-1:0] A_HI = {1'b1, A_LO[W-2:0]};
    // stored selector codes that software maps to normal and swapped
    localparam logic [31:0] SEL_NORMAL = 32'haaaa_aaaa;
    localparam logic [31:0] SEL_SWAP = 32'hbbbb_bbbb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic boot_busy = 1'b1;
    logic bank_mode_wr = 1'b0;
    logic bank_mode_wdata = 1'b0;
    logic remap_wr = 1'b0;
    logic remap_wdata = 1'b0;
    logic app_activate = 1'b0;
    fdbr_pkg::fdbr_req_s req = '0;
    logic dual_bank_q, remap_q, remap_active_q, app_hold_q;
    fdbr_pkg::fdbr_rsp_s rsp_q;
    int errors = 0;
    int compares = 0;

    always #12.5 clk = ~clk;

    fdbr_remap_ctrl fdbr_remap_ctrl_i (.clk(clk), .reset(reset),
        .boot_busy(boot_busy), .bank_mode_wr(bank_mode_wr),
        .bank_mode_wdata(bank_mode_wdata), .remap_wr(remap_wr),
        .remap_wdata(remap_wdata), .app_activate(app_activate), .req(req),
        .dual_bank_q(dual_bank_q), .remap_q(remap_q),
        .remap_active_q(remap_active_q), .app_hold_q(app_hold_q),
        .rsp_q(rsp_q));

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic ctl(input logic d, input logic r, input logic a,
                       input logic h);
        chk(dual_bank_q, d, "bank mode");
        chk(remap_q, r, "remap");
        chk(remap_active_q, a, "swap active");
        chk(app_hold_q, h, "app hold");
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        #1;
        ctl(1'b0, 1'b0, 1'b0, fdbr_pkg::FDBR_HOLD_RST);
        chk(rsp_q, 32'h0, "rsp after reset");
    endtask

    // one strobe cycle; result is visible one edge later
    task automatic wr(input logic bm, input logic bmd, input logic rm,
                      input logic rmd, input logic act);
        @(posedge clk);
        bank_mode_wr <= bm;
        bank_mode_wdata <= bmd;
        remap_wr <= rm;
        remap_wdata <= rmd;
        app_activate <= act;
        @(posedge clk);
        bank_mode_wr <= 1'b0;
        remap_wr <= 1'b0;
        app_activate <= 1'b0;
        #1;
    endtask

    task automatic xl(input logic [W-1:0] a, input logic r,
                      input logic [W-1:0] ea);
        @(posedge clk);
        req <= '{valid: 1'b1, addr: a};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk(rsp_q, {1'b1, r, ea}, "translated access");
        @(posedge clk);
        #1;
        chk(rsp_q.valid, 1'b0, "access shown twice");
    endtask

    // software side: the bench stands for code running from SRAM, so no
    // access is in flight while the mapping moves
    task automatic select_remap(input logic [31:0] word,
                                input logic [31:0] copy);
        // only a known code held twice in agreement may move the mapping
        if (word == copy) begin
            if (word == SEL_NORMAL || word == SEL_SWAP) begin
                wr(1'b0, 1'b0, 1'b1, word == SEL_SWAP, 1'b0);
            end
        end
    endtask

    task automatic s_boot();
        wr(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
        ctl(1'b0, 1'b0, 1'b0, 1'b1);
        xl(A_HI, 1'b0, A_HI);
        @(posedge clk);
        boot_busy <= 1'b0;
    endtask

    task automatic s_single_remap();
        wr(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        ctl(1'b0, 1'b1, 1'b0, 1'b1);
        xl(A_HI, 1'b0, A_HI);
        xl(A_LO, 1'b0, A_LO);
    endtask

    task automatic s_dual();
        // both strobes in one cycle are both taken
        wr(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        ctl(1'b1, 1'b0, 1'b0, 1'b1);
        xl(A_LO, 1'b0, A_LO);
        xl(A_HI, 1'b1, A_HI);
    endtask

    task automatic s_swap();
        select_remap(SEL_SWAP, SEL_NORMAL);
        ctl(1'b1, 1'b0, 1'b0, 1'b1);
        select_remap(SEL_SWAP, SEL_SWAP);
        ctl(1'b1, 1'b1, 1'b1, 1'b1);
        xl(A_LO, 1'b0, A_HI);
        xl(A_HI, 1'b1, A_LO);
        wr(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        ctl(1'b1, 1'b1, 1'b1, 1'b0);
        wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        ctl(1'b0, 1'b1, 1'b0, 1'b0);
        xl(A_LO, 1'b0, A_LO);
        select_remap(SEL_NORMAL, SEL_NORMAL);
        ctl(1'b0, 1'b0, 1'b0, 1'b0);
    endtask

    initial begin
        #100000;
        errors++;
        $display("wrong value at %0t: run hung", $time);
        test_done();
    end

    initial begin
        do_reset();
        s_boot();
        s_single_remap();
        s_dual();
        s_swap();
        do_reset();
        test_done();
    end
endmodule
